// ---- rtl/clcfg_cfg_if.sv ----
/*
   Carrier between the register bank, its decoder and the commutation
   selector. Assumes all three sit on one clock.
*/
`default_nettype none
interface clcfg_cfg_if;
   logic [31:0] word;
   logic [4:0]  fcnt;
   logic [7:0]  upper_mv;
   logic [6:0]  lower_mv;
   logic [3:0]  smp_lo;
   logic [3:0]  smp_hi;
   logic [4:0]  duty_lo;
   logic [4:0]  duty_hi;
   logic        integ_en;
   logic        integ_active;

   modport bank (output word, input fcnt, upper_mv, lower_mv, smp_lo,
                 smp_hi, duty_lo, duty_hi, integ_en, integ_active);
   modport dec  (input word, output fcnt, upper_mv, lower_mv, smp_lo,
                 smp_hi, duty_lo, duty_hi, integ_en);
   modport sw   (input smp_lo, smp_hi, duty_lo, duty_hi, integ_en,
                 output integ_active);
endinterface
`default_nettype wire

// ---- rtl/clcfg_decode.sv ----
/*
   Registered decoder of the configuration word into physical values.
   Assumes a synchronous active-low reset and one clock.
*/
`include "clcfg_map.svh"
`default_nettype none
module clcfg_decode
   import clcfg_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   clcfg_cfg_if.dec  cfg
);
   logic [4:0] fcnt_q,  fcnt_d;
   logic [7:0] upr_q,   upr_d;
   logic [6:0] lwr_q,   lwr_d;
   logic [3:0] slo_q,   slo_d;
   logic [3:0] shi_q,   shi_d;
   logic [4:0] dlo_q,   dlo_d;
   logic [4:0] dhi_q,   dhi_d;
   logic       men_q,   men_d;

   always_comb begin
      fcnt_d = clcfg_fcnt(cfg.word[`CLCFG_FCNT_POS +: 2]);
      upr_d  = clcfg_upper(cfg.word[`CLCFG_UPR_POS +: 2]);
      lwr_d  = clcfg_lower(cfg.word[`CLCFG_LWR_POS +: 2]);
      slo_d  = clcfg_slo(cfg.word[`CLCFG_SLO_POS +: 2]);
      shi_d  = clcfg_shi(cfg.word[`CLCFG_SHI_POS +: 2]);
      dlo_d  = clcfg_duty(cfg.word[`CLCFG_DLO_POS +: 2]);
      dhi_d  = clcfg_duty(cfg.word[`CLCFG_DHI_POS +: 2]);
      men_d  = cfg.word[`CLCFG_MSEL_POS];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fcnt_q <= clcfg_fcnt(2'(`CLCFG_RESET >> `CLCFG_FCNT_POS));
         upr_q  <= clcfg_upper(2'(`CLCFG_RESET >> `CLCFG_UPR_POS));
         lwr_q  <= clcfg_lower(2'(`CLCFG_RESET >> `CLCFG_LWR_POS));
         slo_q  <= clcfg_slo(2'(`CLCFG_RESET >> `CLCFG_SLO_POS));
         shi_q  <= clcfg_shi(2'(`CLCFG_RESET >> `CLCFG_SHI_POS));
         dlo_q  <= clcfg_duty(2'(`CLCFG_RESET >> `CLCFG_DLO_POS));
         dhi_q  <= clcfg_duty(2'(`CLCFG_RESET >> `CLCFG_DHI_POS));
         men_q  <= 1'b0;
      end else begin
         fcnt_q <= fcnt_d;
         upr_q  <= upr_d;
         lwr_q  <= lwr_d;
         slo_q  <= slo_d;
         shi_q  <= shi_d;
         dlo_q  <= dlo_d;
         dhi_q  <= dhi_d;
         men_q  <= men_d;
      end
   end

   assign cfg.fcnt     = fcnt_q;
   assign cfg.upper_mv = upr_q;
   assign cfg.lower_mv = lwr_q;
   assign cfg.smp_lo   = slo_q;
   assign cfg.smp_hi   = shi_q;
   assign cfg.duty_lo  = dlo_q;
   assign cfg.duty_hi  = dhi_q;
   assign cfg.integ_en = men_q;
endmodule
`default_nettype wire

// ---- rtl/clcfg_map.svh ----
/*
   Offsets, field positions and reset value of the closed-loop
   configuration bank. Assumes inclusion by bare name from rtl/.
*/
`ifndef CLCFG_MAP_SVH
`define CLCFG_MAP_SVH

// Register indices; the byte address is four times the index.
`define CLCFG_CFG_IDX    10'h08a
`define CLCFG_STAT_IDX   10'h08b
`define CLCFG_RESET      32'h14000000

`define CLCFG_PAR_POS    31
`define CLCFG_FCNT_POS   29
`define CLCFG_UPR_POS    27
`define CLCFG_LWR_POS    25
`define CLCFG_SLO_POS    23
`define CLCFG_SHI_POS    21
`define CLCFG_DLO_POS    19
`define CLCFG_DHI_POS    17
`define CLCFG_TH2_POS    11
`define CLCFG_TH1_POS    5
`define CLCFG_MSEL_POS   4
`define CLCFG_WIN_POS    1
`define CLCFG_DEN_POS    0

`define CLCFG_RESP_OKAY   2'h0
`define CLCFG_RESP_DECERR 2'h3

`endif

// ---- rtl/clcfg_pkg.sv ----
/*
   Types and code tables of the closed-loop configuration bank.
   Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package clcfg_pkg;

   typedef enum logic [1:0] {
      CLCFG_ZC    = 2'b01,
      CLCFG_INTEG = 2'b10
   } clcfg_mode_e;

   typedef logic [1:0] clcfg_code_t;

   function automatic logic [4:0] clcfg_fcnt(input clcfg_code_t c);
      case (c)
         2'h0: return 5'h0f;
         2'h1: return 5'h14;
         2'h2: return 5'h1e;
         default: return 5'h0c;
      endcase
   endfunction

   // Offset in mV below the motor supply voltage.
   function automatic logic [7:0] clcfg_upper(input clcfg_code_t c);
      case (c)
         2'h0: return 8'h5a;
         2'h1: return 8'h78;
         2'h2: return 8'h96;
         default: return 8'hb4;
      endcase
   endfunction

   function automatic logic [6:0] clcfg_lower(input clcfg_code_t c);
      case (c)
         2'h0: return 7'h1e;
         2'h1: return 7'h3c;
         2'h2: return 7'h5a;
         default: return 7'h78;
      endcase
   endfunction

   function automatic logic [3:0] clcfg_slo(input clcfg_code_t c);
      case (c)
         2'h0: return 4'h3;
         2'h1: return 4'h4;
         2'h2: return 4'h6;
         default: return 4'h8;
      endcase
   endfunction

   function automatic logic [3:0] clcfg_shi(input clcfg_code_t c);
      case (c)
         2'h0: return 4'h4;
         2'h1: return 4'h6;
         2'h2: return 4'h8;
         default: return 4'ha;
      endcase
   endfunction

   function automatic logic [4:0] clcfg_duty(input clcfg_code_t c);
      case (c)
         2'h0: return 5'h0c;
         2'h1: return 5'h0f;
         2'h2: return 5'h12;
         default: return 5'h14;
      endcase
   endfunction

endpackage
`default_nettype wire

// ---- rtl/clcfg_switch.sv ----
/*
   Selector between zero-crossing and integration commutation.
   Assumes sample count and duty come from logic on the same clock.
*/
`default_nettype none
module clcfg_switch
   import clcfg_pkg::*;
#(
   parameter int SAMPLE_W = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [SAMPLE_W-1:0] sample_count_in,
   input  wire logic [6:0]          duty_pct_in,
   clcfg_cfg_if.sw                  cfg
);
   clcfg_mode_e state_q, state_d;
   logic        fall_back;
   logic        go_integ;

   // Hysteresis comes from the separate low and high thresholds.
   always_comb begin
      fall_back = !cfg.integ_en
                | (sample_count_in < SAMPLE_W'(cfg.smp_lo))
                | (duty_pct_in < 7'(cfg.duty_lo));
      go_integ  = cfg.integ_en
                & ((sample_count_in > SAMPLE_W'(cfg.smp_hi))
                | (duty_pct_in > 7'(cfg.duty_hi)));
      state_d   = state_q;
      unique case (state_q)
         CLCFG_ZC:    if (go_integ) state_d = CLCFG_INTEG;
         CLCFG_INTEG: if (fall_back) state_d = CLCFG_ZC;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= CLCFG_ZC;
      end else begin
         state_q <= state_d;
      end
   end

   // One-hot state: the integration bit is itself the registered output.
   assign cfg.integ_active = state_q[1];
endmodule
`default_nettype wire

// ---- rtl/clcfg_top.sv ----
/*
   Closed-loop configuration bank with AXI4-Lite access, field decoder
   and commutation method selector. Assumes one 100 MHz clock, a
   synchronous active-low reset, and sample count and duty inputs
   produced by logic on the same clock.
*/
`include "clcfg_map.svh"
`default_nettype none

// Notes on behaviour
// - Word at index 8Ah is read/write, resets to 14000000h.
// - Bits 30-29 pick demag check sample count: 15, 20, 30, 12.
// - Bits 28-27 pick upper bound: supply minus 90 to 180 mV.
// - Bits 26-25 pick lower bound: 30, 60, 90, 120 mV.
// - Below low sample threshold, integration falls back to zero crossing.
// - Above high sample threshold, zero crossing moves to integration.
// - Below low duty threshold, integration falls back to zero crossing.
// - Above high duty threshold, zero crossing moves to integration.
module clcfg_top
   import clcfg_pkg::*;
#(
   parameter int ADDR_W   = 12,
   parameter int SAMPLE_W = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic [2:0]          s_axi_awprot,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic [2:0]          s_axi_arprot,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic [SAMPLE_W-1:0] sample_count_in,
   input  wire logic [6:0]          duty_pct_in,
   output var  logic [4:0]          demag_check_sample_count,
   output var  logic [7:0]          demag_check_upper_bound,
   output var  logic [6:0]          demag_check_lower_bound,
   output var  logic [5:0]          rising_backemf_integration_threshold,
   output var  logic [5:0]          falling_backemf_integration_threshold,
   output var  logic                integration_method_select,
   output var  logic [2:0]          demag_max_window,
   output var  logic                dynamic_demag_enable,
   output var  logic                integration_active
);

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
      return 10'(a >> 2);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   clcfg_cfg_if cfg_bus ();

   logic [31:0]       cfg_q,     cfg_d;
   logic              aw_got_q,  aw_got_d;
   logic              w_got_q,   w_got_d;
   logic [ADDR_W-1:0] waddr_q,   waddr_d;
   logic [31:0]       wdata_q,   wdata_d;
   logic [3:0]        wstrb_q,   wstrb_d;
   logic              awrdy_q,   awrdy_d;
   logic              wrdy_q,    wrdy_d;
   logic              bvalid_q,  bvalid_d;
   logic [1:0]        bresp_q,   bresp_d;
   logic              arrdy_q,   arrdy_d;
   logic              rvalid_q,  rvalid_d;
   logic [31:0]       rdata_q,   rdata_d;
   logic [1:0]        rresp_q,   rresp_d;
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic              do_write;
   logic [9:0]        widx;
   logic [9:0]        ridx;

   // ------------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------------
   // Address and data are held separately so either may arrive first.
   always_comb begin
      aw_take  = s_axi_awvalid & awrdy_q;
      w_take   = s_axi_wvalid & wrdy_q;
      aw_got_d = aw_got_q | aw_take;
      w_got_d  = w_got_q | w_take;
      waddr_d  = aw_take ? s_axi_awaddr : waddr_q;
      wdata_d  = w_take ? s_axi_wdata : wdata_q;
      wstrb_d  = w_take ? s_axi_wstrb : wstrb_q;
      cfg_d    = cfg_q;
      bvalid_d = bvalid_q & ~s_axi_bready;
      bresp_d  = bresp_q;
      widx     = word_idx(waddr_d);
      do_write = aw_got_d & w_got_d & ~bvalid_q;
      if (do_write) begin
         bvalid_d = 1'b1;
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
         if (widx == `CLCFG_CFG_IDX) begin
            cfg_d   = merge(cfg_q, wdata_d, wstrb_d);
            bresp_d = `CLCFG_RESP_OKAY;
         end else if (widx == `CLCFG_STAT_IDX) begin
            bresp_d = `CLCFG_RESP_OKAY;
         end else begin
            bresp_d = `CLCFG_RESP_DECERR;
         end
      end
      awrdy_d = ~aw_got_d & ~bvalid_d;
      wrdy_d  = ~w_got_d & ~bvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q    <= `CLCFG_RESET;
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         waddr_q  <= '0;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
         awrdy_q  <= 1'b0;
         wrdy_q   <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= `CLCFG_RESP_OKAY;
      end else begin
         cfg_q    <= cfg_d;
         aw_got_q <= aw_got_d;
         w_got_q  <= w_got_d;
         waddr_q  <= waddr_d;
         wdata_q  <= wdata_d;
         wstrb_q  <= wstrb_d;
         awrdy_q  <= awrdy_d;
         wrdy_q   <= wrdy_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
      end
   end

   // ------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------
   always_comb begin
      ar_take  = s_axi_arvalid & arrdy_q;
      ridx     = word_idx(s_axi_araddr);
      rvalid_d = rvalid_q & ~s_axi_rready;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (ar_take) begin
         rvalid_d = 1'b1;
         rresp_d  = `CLCFG_RESP_OKAY;
         if (ridx == `CLCFG_CFG_IDX) begin
            rdata_d = cfg_q;
         end else if (ridx == `CLCFG_STAT_IDX) begin
            rdata_d = {31'h0, cfg_bus.integ_active};
         end else begin
            rdata_d = 32'h00000000;
            rresp_d = `CLCFG_RESP_DECERR;
         end
      end
      arrdy_d = ~rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arrdy_q  <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `CLCFG_RESP_OKAY;
      end else begin
         arrdy_q  <= arrdy_d;
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   // ------------------------------------------------------------------
   // Decoder and commutation selector
   // ------------------------------------------------------------------
   assign cfg_bus.word = cfg_q;

   clcfg_decode u_decode (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (cfg_bus)
   );

   clcfg_switch #(
      .SAMPLE_W (SAMPLE_W)
   ) u_switch (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .sample_count_in (sample_count_in),
      .duty_pct_in     (duty_pct_in),
      .cfg             (cfg_bus)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign s_axi_awready = awrdy_q;
   assign s_axi_wready  = wrdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign demag_check_sample_count = cfg_bus.fcnt;
   assign demag_check_upper_bound  = cfg_bus.upper_mv;
   assign demag_check_lower_bound  = cfg_bus.lower_mv;
   assign integration_active       = cfg_bus.integ_active;
   assign rising_backemf_integration_threshold =
      cfg_q[`CLCFG_TH1_POS +: 6];
   assign falling_backemf_integration_threshold =
      cfg_q[`CLCFG_TH2_POS +: 6];
   assign integration_method_select = cfg_q[`CLCFG_MSEL_POS];
   assign demag_max_window          = cfg_q[`CLCFG_WIN_POS +: 3];
   assign dynamic_demag_enable      = cfg_q[`CLCFG_DEN_POS];

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic full_cfg_wr;
   assign full_cfg_wr = do_write & (widx == `CLCFG_CFG_IDX)
                      & (wstrb_d == 4'hf);

   reset_value_a: assert property (
      $rose(aresetn) |-> cfg_q == `CLCFG_RESET)
      else $error("config word not at reset value");

   cfg_write_a: assert property (
      full_cfg_wr |=> cfg_q == $past(wdata_d) ##0 s_axi_bvalid)
      else $error("full write did not land with a response");

   cfg_read_a: assert property (
      ar_take && ridx == `CLCFG_CFG_IDX
      |=> s_axi_rvalid && s_axi_rdata == $past(cfg_q))
      else $error("read of config word returned wrong data");

   count_decode_a: assert property (
      full_cfg_wr |-> ##2 demag_check_sample_count
         == clcfg_fcnt($past(wdata_d[`CLCFG_FCNT_POS +: 2], 2)))
      else $error("sample count decode wrong");

   upper_decode_a: assert property (
      demag_check_upper_bound
         == clcfg_upper($past(cfg_q[`CLCFG_UPR_POS +: 2])))
      else $error("upper bound decode wrong");

   lower_decode_a: assert property (
      demag_check_lower_bound
         == clcfg_lower($past(cfg_q[`CLCFG_LWR_POS +: 2])))
      else $error("lower bound decode wrong");

   sample_fall_a: assert property (
      integration_active
      && sample_count_in < SAMPLE_W'(cfg_bus.smp_lo)
      |=> !integration_active)
      else $error("no fall back below low sample threshold");

   sample_rise_a: assert property (
      !integration_active && cfg_bus.integ_en
      && sample_count_in > SAMPLE_W'(cfg_bus.smp_hi)
      && duty_pct_in >= 7'(cfg_bus.duty_lo)
      |=> integration_active)
      else $error("no move above high sample threshold");

   duty_fall_a: assert property (
      integration_active && duty_pct_in < 7'(cfg_bus.duty_lo)
      |=> !integration_active)
      else $error("no fall back below low duty threshold");

   duty_rise_a: assert property (
      !integration_active && cfg_bus.integ_en
      && duty_pct_in > 7'(cfg_bus.duty_hi)
      |=> integration_active)
      else $error("no move above high duty threshold");

   field_map_a: assert property (
      full_cfg_wr |=> dynamic_demag_enable == $past(wdata_d[0])
         && demag_max_window == $past(wdata_d[3:1])
         && integration_method_select == $past(wdata_d[4]))
      else $error("low fields not at their bit positions");

   cover_cfg_write_c: cover property (full_cfg_wr ##1 s_axi_bvalid);
   cover_bad_read_c:  cover property (
      s_axi_rvalid && s_axi_rresp == `CLCFG_RESP_DECERR);
   cover_to_integ_c:  cover property (
      !integration_active ##1 integration_active);
   cover_to_zc_c:     cover property (
      integration_active ##1 !integration_active);

endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
/*
   Self-checking bench of the closed-loop configuration bank: AXI4-Lite
   accesses, field decode and commutation method selection.
   Assumes the design files under rtl/ and no other model.
*/
`default_nettype none
module testbench
   import clcfg_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals and design
   // ----------------------------------------------------------------
   logic        aclk, aresetn;
   logic [11:0] awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  smp;
   logic [6:0]  duty;
   logic [4:0]  fcnt;
   logic [7:0]  upr;
   logic [6:0]  lwr;
   logic [5:0]  th_r, th_f;
   logic        msel, den, active;
   logic [2:0]  win;
   int          errors, cmp_count;

   // Expected decodes per field code, and the commutation steps.
   logic [7:0]  fc_t [4] = '{8'd15, 8'd20, 8'd30, 8'd12};
   logic [7:0]  up_t [4] = '{8'd90, 8'd120, 8'd150, 8'd180};
   logic [7:0]  lo_t [4] = '{8'd30, 8'd60, 8'd90, 8'd120};
   logic [7:0]  st_s [8] = '{8'd6, 8'd7, 8'd4, 8'd3, 8'd5, 8'd5, 8'd5,
                             8'd5};
   logic [6:0]  st_d [8] = '{7'd15, 7'd15, 7'd15, 7'd15, 7'd20, 7'd21,
                             7'd12, 7'd11};
   logic [31:0] st_e     = 32'h00000066;

   clcfg_top dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_count_in(smp), .duty_pct_in(duty),
      .demag_check_sample_count(fcnt), .demag_check_upper_bound(upr),
      .demag_check_lower_bound(lwr),
      .rising_backemf_integration_threshold(th_r),
      .falling_backemf_integration_threshold(th_f),
      .integration_method_select(msel), .demag_max_window(win),
      .dynamic_demag_enable(den), .integration_active(active));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The leading edge keeps a released handshake from being raised again
   // in the same time step.
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      r = bresp;
      bready <= 1'b0;
      if (n == 200) begin
         errors++;
         tally_and_finish();
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n == 200) begin
         errors++;
         tally_and_finish();
      end
   endtask

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      logic [31:0] d, w;
      logic [1:0]  r, c;
      errors = 0;
      cmp_count = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      smp = '0;
      duty = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);

      axi_read(12'h228, d, r);
      check("reset word", d, 32'h14000000);
      check("reset count", 32'(fcnt), 32'd15);
      check("reset upper", 32'(upr), 32'd150);
      check("reset lower", 32'(lwr), 32'd90);
      check("reset active", 32'(active), 32'd0);
      $display("test reset done");

      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         w = {c[0], {7{c}}, 6'(8 * i + 3), 6'(63 - 5 * i), c[0],
              3'(2 * i + 1), c[1]};
         axi_write(12'h228, w, 4'hf, r);
         check("write resp", 32'(r), 32'h0);
         axi_read(12'h228, d, r);
         check("readback", d, w);
         check("count", 32'(fcnt), 32'(fc_t[i]));
         check("upper", 32'(upr), 32'(up_t[i]));
         check("lower", 32'(lwr), 32'(lo_t[i]));
         check("fields", {th_f, th_r, msel, win, den}, w[16:0]);
      end
      $display("test decode done");

      axi_write(12'h228, 32'h14000000, 4'hf, r);
      axi_write(12'h228, 32'hffffffff, 4'h1, r);
      axi_read(12'h228, d, r);
      check("byte strobe", d, 32'h140000ff);
      axi_write(12'h300, 32'h12345678, 4'hf, r);
      check("unmapped bresp", 32'(r), 32'h3);
      axi_read(12'h300, d, r);
      check("unmapped rdata", d, 32'h0);
      check("unmapped rresp", 32'(r), 32'h3);
      axi_read(12'h228, d, r);
      check("word kept", d, 32'h140000ff);
      $display("test access done");

      // Low 4, high 6 samples; low 12 %, high 20 % duty; integration on.
      axi_write(12'h228, 32'h00a60010, 4'hf, r);
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         smp <= st_s[i];
         duty <= st_d[i];
         repeat (3) @(posedge aclk);
         check("active", 32'(active), 32'(st_e[i]));
         axi_read(12'h22c, d, r);
         check("status", d, 32'(st_e[i]));
      end
      axi_write(12'h22c, 32'h0, 4'hf, r);
      check("status write resp", 32'(r), 32'h0);
      $display("test commutation done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
